// *** common/microstep_pkg.sv ***
// Constants, types and register map of the microstep translator.
// Assumes a 32-bit APB3 register bus and a 6-bit phase current table.
package microstep_pkg;

  // Step angle index: 64 positions, 0 to 63
  localparam int INDEX_W = 6;
  localparam int MAG_W = 6;
  localparam logic [5:0] MAX_INDEX = 6'h3F;

  // Sixteen index positions per full step, four full steps per cycle
  localparam logic [5:0] STEP_FULL = 6'h10;
  localparam logic [5:0] STEP_HALF = 6'h08;
  localparam logic [5:0] STEP_QUARTER = 6'h04;
  localparam logic [5:0] STEP_SIXTEENTH = 6'h01;
  localparam logic [5:0] FULL_OFFSET = 6'h08;
  localparam logic [5:0] ZERO_OFFSET = 6'h00;

  // Index after reset, and the direction level that means forward
  localparam logic [5:0] HOME_INDEX = 6'h08;
  localparam logic DIR_FORWARD = 1'b1;

  // APB register map, byte addresses
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STEP_CHANGE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PHASE = 8'h0C;

  // Field positions and reset values
  localparam int CTRL_RES_LSB = 0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STEP_CHANGE_LSB = 0;
  localparam int STATUS_ANGLE_LSB = 0;
  localparam int STATUS_RES_LSB = 6;
  localparam int STATUS_DIR_BIT = 8;
  localparam int PHASE_A_LSB = 0;
  localparam int PHASE_B_LSB = 8;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Largest table level, the full current magnitude of either sign
  localparam logic [5:0] LEVEL_MAX = 6'h3F;

  typedef enum logic [1:0] {
    RES_FULL = 2'b00,
    RES_HALF = 2'b01,
    RES_QUARTER = 2'b10,
    RES_SIXTEENTH = 2'b11
  } resolution_e;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ACCESS = 1'b1
  } apb_phase_e;

  // Current demand of one motor phase
  typedef struct packed {
    logic negative;
    logic [5:0] magnitude;
  } phase_current_s;

endpackage : microstep_pkg

// *** rtl/phase_current_lookup.sv ***
// Phase current table: maps a step angle index to both phase demands.
// Assumes the index is a registered value in the pclk domain.
`timescale 1ns/1ps
module phase_current_lookup (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] angle_index,
  output microstep_pkg::phase_current_s phase_a,
  output microstep_pkg::phase_current_s phase_b
);

  // Quarter-wave sine level for offsets 0..16 of one full step
  function automatic logic [5:0] sine_level(input logic [4:0] k);
    logic [5:0] level;
    level = microstep_pkg::LEVEL_MAX;
    case (k)
      5'h00: level = 6'h00;
      5'h01: level = 6'h06;
      5'h02: level = 6'h0C;
      5'h03: level = 6'h12;
      5'h04: level = 6'h18;
      5'h05: level = 6'h1E;
      5'h06: level = 6'h23;
      5'h07: level = 6'h28;
      5'h08: level = 6'h2D;
      5'h09: level = 6'h31;
      5'h0A: level = 6'h34;
      5'h0B: level = 6'h38;
      5'h0C: level = 6'h3A;
      5'h0D: level = 6'h3C;
      5'h0E: level = 6'h3E;
      default: level = microstep_pkg::LEVEL_MAX;
    endcase
    return level;
  endfunction : sine_level

  microstep_pkg::phase_current_s phase_q [2];
  logic [1:0] quadrant;
  logic [4:0] offset;
  logic [4:0] mirrored;

  assign quadrant = angle_index[5:4];
  assign offset = {1'b0, angle_index[3:0]};
  assign mirrored = 5'h10 - offset;

  // Phase 0 is A (sine), phase 1 is B (cosine) of the electrical angle
  for (genvar p = 0; p < 2; p++)
  begin : g_phase
    microstep_pkg::phase_current_s next_phase;
    logic mirror;
    logic negative;

    assign mirror = (p == 0) ? quadrant[0] : ~quadrant[0];
    assign negative = (p == 0) ? quadrant[1] : quadrant[1] ^ quadrant[0];

    always_comb
    begin
      next_phase.magnitude = sine_level(mirror ? mirrored : offset);
      next_phase.negative = negative & (|next_phase.magnitude);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        phase_q[p] <= '0;
      else
        phase_q[p] <= next_phase;
    end
  end

  assign phase_a = phase_q[0];
  assign phase_b = phase_q[1];

endmodule : phase_current_lookup

// *** rtl/microstep_translator.sv ***
// Step and direction translator with an APB3 register slave.
// Assumes step, direction and resolution pins are synchronous to pclk
// and meet setup and hold around its rising edge.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module microstep_translator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_pulse,
  input wire logic direction,
  input wire logic resolution_select_low,
  input wire logic resolution_select_high,
  output logic [5:0] angle_index,
  output microstep_pkg::phase_current_s phase_a,
  output microstep_pkg::phase_current_s phase_b
);

  // Translator state
  logic step_prev;
  logic next_step_prev;
  logic [5:0] next_angle_index;
  logic [1:0] ctrl_res;
  logic [1:0] next_ctrl_res;

  // APB slave state
  microstep_pkg::apb_phase_e apb_phase;
  microstep_pkg::apb_phase_e next_apb_phase;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Decoded bus events
  logic setup;
  logic access_done;
  logic write_ctrl;
  logic serial_write;
  logic addr_mapped;
  logic [5:0] step_change;

  // Translator datapath
  microstep_pkg::resolution_e res_eff;
  logic step_rise;
  logic [5:0] step_size;
  logic [5:0] grid_offset;
  logic [5:0] grid_mask;
  logic [5:0] base;
  logic [5:0] next_pos;
  logic [5:0] after_step;

  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign addr_mapped = (paddr == microstep_pkg::OFF_CTRL)
                     | (paddr == microstep_pkg::OFF_STEP_CHANGE)
                     | (paddr == microstep_pkg::OFF_STATUS)
                     | (paddr == microstep_pkg::OFF_PHASE);
  assign write_ctrl = access_done & pwrite
                    & (paddr == microstep_pkg::OFF_CTRL);
  assign serial_write = access_done & pwrite
                      & (paddr == microstep_pkg::OFF_STEP_CHANGE);
  assign step_change = pwdata[microstep_pkg::STEP_CHANGE_LSB +: 6];

  // Effective select: pin level OR register bit
  assign res_eff = microstep_pkg::resolution_e'(
    {resolution_select_high, resolution_select_low} | ctrl_res);

  assign step_rise = step_pulse & ~step_prev;

  // Grid of permitted positions for the effective resolution
  always_comb
  begin
    step_size = microstep_pkg::STEP_SIXTEENTH;
    grid_offset = microstep_pkg::ZERO_OFFSET;
    case (res_eff)
      microstep_pkg::RES_FULL:
      begin
        step_size = microstep_pkg::STEP_FULL;
        grid_offset = microstep_pkg::FULL_OFFSET;
      end
      microstep_pkg::RES_HALF:
      begin
        step_size = microstep_pkg::STEP_HALF;
      end
      microstep_pkg::RES_QUARTER:
      begin
        step_size = microstep_pkg::STEP_QUARTER;
      end
      microstep_pkg::RES_SIXTEENTH:
      begin
        step_size = microstep_pkg::STEP_SIXTEENTH;
      end
      default:
      begin
        step_size = microstep_pkg::STEP_SIXTEENTH;
      end
    endcase
  end

  // Next permitted position in the commanded direction, modulo 64
  always_comb
  begin
    grid_mask = ~(step_size - 6'h01);
    base = angle_index - grid_offset;
    if (direction == microstep_pkg::DIR_FORWARD)
      next_pos = (base & grid_mask) + step_size + grid_offset;
    else
      next_pos = ((base - 6'h01) & grid_mask) + grid_offset;
  end

  // Serial step change adds its signed value regardless of resolution
  always_comb
  begin
    next_step_prev = step_pulse;
    after_step = step_rise ? next_pos : angle_index;
    next_angle_index = serial_write ? after_step + step_change
                                    : after_step;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_prev <= 1'b0;
      angle_index <= microstep_pkg::HOME_INDEX;
    end
    else
    begin
      step_prev <= next_step_prev;
      angle_index <= next_angle_index;
    end
  end

  // Configuration register
  always_comb
  begin
    next_ctrl_res = ctrl_res;
    if (write_ctrl)
      next_ctrl_res = pwdata[microstep_pkg::CTRL_RES_LSB +: 2];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_res <= microstep_pkg::CTRL_RESET;
    else
      ctrl_res <= next_ctrl_res;
  end

  // APB slave: read data captured in setup, answered in the first access cycle
  always_comb
  begin
    next_apb_phase = apb_phase;
    next_prdata = prdata;
    next_pready = pready;
    next_pslverr = pslverr;
    case (apb_phase)
      microstep_pkg::PH_IDLE:
      begin
        if (setup)
        begin
          next_apb_phase = microstep_pkg::PH_ACCESS;
          next_pready = 1'b1;
          next_pslverr = ~addr_mapped;
          next_prdata = microstep_pkg::READ_ZERO;
          if (!pwrite)
          begin
            case (paddr)
              microstep_pkg::OFF_CTRL:
                next_prdata[microstep_pkg::CTRL_RES_LSB +: 2] = ctrl_res;
              microstep_pkg::OFF_STATUS:
              begin
                next_prdata[microstep_pkg::STATUS_ANGLE_LSB +: 6] =
                  angle_index;
                next_prdata[microstep_pkg::STATUS_RES_LSB +: 2] = res_eff;
                next_prdata[microstep_pkg::STATUS_DIR_BIT] = direction;
              end
              microstep_pkg::OFF_PHASE:
              begin
                next_prdata[microstep_pkg::PHASE_A_LSB +: 7] = phase_a;
                next_prdata[microstep_pkg::PHASE_B_LSB +: 7] = phase_b;
              end
              default:
                next_prdata = microstep_pkg::READ_ZERO;
            endcase
          end
        end
      end
      microstep_pkg::PH_ACCESS:
      begin
        if (access_done)
        begin
          next_apb_phase = microstep_pkg::PH_IDLE;
          next_pready = 1'b0;
          next_pslverr = 1'b0;
          next_prdata = microstep_pkg::READ_ZERO;
        end
      end
      default:
      begin
        next_apb_phase = microstep_pkg::PH_IDLE;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = microstep_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_phase <= microstep_pkg::PH_IDLE;
      prdata <= microstep_pkg::READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      apb_phase <= next_apb_phase;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  phase_current_lookup u_lookup (
    .pclk(pclk),
    .presetn(presetn),
    .angle_index(angle_index),
    .phase_a(phase_a),
    .phase_b(phase_b)
  );

  // Checks
  logic bus_quiet;
  assign bus_quiet = ~serial_write;

  sequence step_in(microstep_pkg::resolution_e r);
    step_rise && bus_quiet && res_eff == r;
  endsequence

  sequence fwd_from_59;
    step_rise && bus_quiet && direction == microstep_pkg::DIR_FORWARD
      && angle_index == 6'h3B;
  endsequence

  a_sixteenth_move: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_in(microstep_pkg::RES_SIXTEENTH) |=>
      angle_index == ($past(direction) == microstep_pkg::DIR_FORWARD
        ? 6'($past(angle_index) + 6'h01)
        : 6'($past(angle_index) - 6'h01)))
    else $error("sixteenth step did not move index by one");

  a_full_grid: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_in(microstep_pkg::RES_FULL) |=>
      angle_index[3:0] == 4'h8 && angle_index != $past(angle_index))
    else $error("full step left the 8/24/40/56 positions");

  a_half_grid: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_in(microstep_pkg::RES_HALF) |=> angle_index[2:0] == 3'h0)
    else $error("half step off a multiple of eight");

  a_quarter_grid: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_in(microstep_pkg::RES_QUARTER) |=> angle_index[1:0] == 2'h0)
    else $error("quarter step off a multiple of four");

  a_change_from_59: assert property (
    @(posedge pclk) disable iff (!presetn)
    fwd_from_59 |=> angle_index == (
      $past(res_eff) == microstep_pkg::RES_QUARTER ? 6'h3C :
      $past(res_eff) == microstep_pkg::RES_HALF ? 6'h00 :
      $past(res_eff) == microstep_pkg::RES_FULL ? 6'h08 : 6'h3C))
    else $error("wrong target after resolution change at 59");

  a_reverse_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_in(microstep_pkg::RES_SIXTEENTH) and
      (angle_index == 6'h00 && direction != microstep_pkg::DIR_FORWARD)
      |=> angle_index == microstep_pkg::MAX_INDEX)
    else $error("reverse step from 0 did not wrap to 63");

  a_no_edge_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    step_pulse && step_prev && bus_quiet |=> $stable(angle_index))
    else $error("index moved while step stayed high");

  a_serial_add: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_write && !step_rise |=>
      angle_index == 6'($past(angle_index) + $past(step_change)))
    else $error("serial step change not added as written");

  a_select_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ctrl_res == 2'h0 &&
      angle_index == microstep_pkg::HOME_INDEX)
    else $error("select bits or index wrong after reset");

  a_zero_angle: assert property (
    @(posedge pclk) disable iff (!presetn)
    angle_index == 6'h00 ##1 $stable(angle_index) |->
      phase_b.magnitude == microstep_pkg::LEVEL_MAX && !phase_b.negative
      && phase_a.magnitude == 6'h00)
    else $error("index 0 is not phase B full with phase A zero");

  a_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && apb_phase == microstep_pkg::PH_IDLE |=> pready ##1 !pready)
    else $error("APB answer not a single ready cycle after setup");

endmodule : microstep_translator

// *** tb/step_controller.sv ***
// Model of the controller that drives the step and resolution pins.
// Assumes pclk is the translator's clock; pins change after its edge.
`timescale 1ns/1ps
module step_controller (
  input wire logic pclk,
  output logic step_pulse,
  output logic direction,
  output logic resolution_select_low,
  output logic resolution_select_high
);
  initial
  begin
    step_pulse = 1'b0;
    direction = microstep_pkg::DIR_FORWARD;
    resolution_select_low = 1'b0;
    resolution_select_high = 1'b0;
  end

  // Step is only issued while no serial write is in flight
  task automatic step(input logic fwd, input int hold);
    @(posedge pclk);
    direction <= fwd ? microstep_pkg::DIR_FORWARD
                     : ~microstep_pkg::DIR_FORWARD;
    @(posedge pclk);
    step_pulse <= 1'b1;
    repeat (hold) @(posedge pclk);
    step_pulse <= 1'b0;
    @(posedge pclk);
  endtask : step

  // Pins are held low when software owns the resolution
  task automatic set_pins(input logic [1:0] code);
    @(posedge pclk);
    resolution_select_high <= code[1];
    resolution_select_low <= code[0];
  endtask : set_pins
endmodule : step_controller

// *** tb/microstep_translator_bench.sv ***
// Self-checking bench for the step translator and its APB registers.
// Assumes APB answers within 16 access cycles and the controller model beside it.
`timescale 1ns/1ps
module microstep_translator_bench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic step_pulse;
  logic direction;
  logic res_low;
  logic res_high;
  logic [5:0] angle_index;
  microstep_pkg::phase_current_s phase_a;
  microstep_pkg::phase_current_s phase_b;
  int failures;
  int comparisons;
  int cycles;
  logic [5:0] idx;
  logic [31:0] rd;
  logic err;
  logic [5:0] jump [3] = '{6'h3C, 6'h00, 6'h08};

  microstep_translator DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse(step_pulse), .direction(direction),
    .resolution_select_low(res_low), .resolution_select_high(res_high),
    .angle_index(angle_index), .phase_a(phase_a), .phase_b(phase_b));

  step_controller ctrl (.pclk(pclk), .step_pulse(step_pulse),
    .direction(direction), .resolution_select_low(res_low),
    .resolution_select_high(res_high));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h0000_0001, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Nearest permitted index in the chosen direction
  function automatic logic [5:0] next_pos(logic [5:0] i, logic [1:0] r,
                                          logic f);
    logic [5:0] c;
    c = i;
    for (int k = 0; k < 16; k++)
    begin
      c = f ? c + 6'h01 : c - 6'h01;
      if (r == 2'b11 || (r == 2'b10 && c[1:0] == 2'b00) ||
          (r == 2'b01 && c[2:0] == 3'b000) || (r == 2'b00 && c[3:0] == 4'h8))
        return c;
    end
    return c;
  endfunction : next_pos

  task automatic do_step(input logic f, input logic [1:0] r, input int h);
    ctrl.step(f, h);
    idx = next_pos(idx, r, f);
    chk("angle_index", 32'(idx), 32'(angle_index));
  endtask : do_step

  // Serial move by a signed change, resolution plays no part
  task automatic goto(input logic [5:0] target);
    apb(1'b1, microstep_pkg::OFF_STEP_CHANGE, 32'(target - idx));
    idx = target;
    repeat (2) @(posedge pclk);
    chk("serial_index", 32'(idx), 32'(angle_index));
  endtask : goto

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    idx = microstep_pkg::HOME_INDEX;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("home", 32'(idx), 32'(angle_index));
    apb(1'b0, microstep_pkg::OFF_CTRL, 32'h0000_0000);
    chk("ctrl_reset", 32'h0000_0000, rd & 32'h0000_0003);
    ctrl.set_pins(2'b11);
    goto(6'h3E);
    repeat (3) do_step(1'b1, 2'b11, 1);
    repeat (3) do_step(1'b0, 2'b11, 1);
    for (int r = 0; r < 4; r++)
    begin
      ctrl.set_pins(2'(r));
      goto(6'h05);
      repeat (5) do_step(1'b1, 2'(r), 1);
      repeat (5) do_step(1'b0, 2'(r), 1);
    end
    for (int j = 0; j < 3; j++)
    begin
      ctrl.set_pins(2'b11);
      goto(6'h3B);
      ctrl.set_pins(2'(2 - j));
      ctrl.step(1'b1, 1);
      idx = jump[j];
      chk("from_59", 32'(idx), 32'(angle_index));
    end
    ctrl.set_pins(2'b00);
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, microstep_pkg::OFF_CTRL, 32'(r));
      apb(1'b0, microstep_pkg::OFF_STATUS, 32'h0000_0000);
      chk("status_res", 32'(r), 32'(rd[7:6]));
      goto(6'h05);
      do_step(1'b1, 2'(r), 1);
    end
    apb(1'b1, microstep_pkg::OFF_CTRL, 32'h0000_0001);
    ctrl.set_pins(2'b10);
    apb(1'b0, microstep_pkg::OFF_STATUS, 32'h0000_0000);
    chk("or_res", 32'h0000_0003, 32'(rd[7:6]));
    ctrl.set_pins(2'b00);
    apb(1'b1, microstep_pkg::OFF_CTRL, 32'h0000_0000);
    goto(idx + 6'h03);
    do_step(1'b1, 2'b00, 6);
    apb(1'b0, microstep_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status_angle", 32'(idx), 32'(rd[5:0]));
    chk("status_dir", 32'h0000_0001, 32'(rd[8]));
    goto(6'h00);
    repeat (2) @(posedge pclk);
    chk("b_mag", 32'(microstep_pkg::LEVEL_MAX),
        32'(phase_b.magnitude));
    chk("b_sign", 32'h0000_0000, 32'(phase_b.negative));
    chk("a_mag", 32'h0000_0000, 32'(phase_a.magnitude));
    goto(6'h20);
    repeat (2) @(posedge pclk);
    chk("b_neg", 32'h0000_0001, 32'(phase_b.negative));
    apb(1'b0, microstep_pkg::OFF_PHASE, 32'h0000_0000);
    chk("ph_reg", 32'(microstep_pkg::LEVEL_MAX), 32'(rd[13:8]));
    chk("ph_neg", 32'h0000_0001, 32'(rd[14]));
    apb(1'b1, 8'h10, 32'h0000_0003);
    chk("unmapped_err", 32'h0000_0001, 32'(err));
    apb(1'b0, microstep_pkg::OFF_CTRL, 32'h0000_0000);
    chk("ctrl_kept", 32'h0000_0000, rd & 32'h0000_0003);
    goto(6'h08);
    test_done();
  end
endmodule : microstep_translator_bench
